// *** logic/ea_offset_adder.sv ***
// Three-term adder with selectable subtract of the displacement.
// Width wraps at 32 bits; narrower wrap is applied by the caller.
module ea_offset_adder (
  // Operands
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_index,
  input wire logic [31:0] i_disp,
  input wire logic i_sub_disp,
  // Sum
  output logic [31:0] o_sum
);
  // Carry out of bit 31 is dropped
  assign o_sum = i_sub_disp ? (i_base + i_index - i_disp) : (i_base + i_index + i_disp);
endmodule : ea_offset_adder

// *** logic/ea_operand_extend.sv ***
// Sign or zero extension of index and displacement operands to 32 bits.
// Purely combinational; fed from decode on the same clock.
module ea_operand_extend
  import ea_pkg::*;
(
  // Index input
  input wire logic [31:0] i_index,
  input wire logic i_index_long,
  // Displacement input
  input wire logic [31:0] i_disp,
  input wire logic [1:0] i_disp_w,
  input wire logic i_disp_zero_ext,
  // Extended outputs
  output logic [31:0] o_index,
  output logic [31:0] o_disp
);
  // Word index gets its sign replicated
  assign o_index = i_index_long ? i_index : {{16{i_index[15]}}, i_index[15:0]};
  // Short displacements extend with sign, or with zeros when asked
  wire logic fill8 = i_disp[7] & ~i_disp_zero_ext;
  wire logic fill16 = i_disp[15] & ~i_disp_zero_ext;
  assign o_disp = (i_disp_w == DISP_W8) ? {{24{fill8}}, i_disp[7:0]} :
                  (i_disp_w == DISP_W16) ? {{16{fill16}}, i_disp[15:0]} : i_disp;
endmodule : ea_operand_extend

// *** logic/ea_pkg.sv ***
// Shared constants and types for the effective address unit.
// Assumes a single core clock and a synchronous active-high reset.
package ea_pkg;
  // Address representation setting, two bits of the flag and control word
  localparam logic [1:0] REP_COMPACT = 2'h0;
  localparam logic [1:0] REP_SEGMENTED = 2'h1;
  localparam logic [1:0] REP_LINEAR = 2'h2;
  // Segment-size bit position and field widths
  localparam int SEG_SIZE_BIT = 31;
  localparam int SMALL_OFS_W = 16;
  localparam int LARGE_OFS_W = 24;
  localparam int SMALL_SEG_W = 15;
  localparam int LARGE_SEG_W = 7;
  // Displacement encoded widths (selector)
  localparam logic [1:0] DISP_W8 = 2'h0;
  localparam logic [1:0] DISP_W16 = 2'h1;
  localparam logic [1:0] DISP_W32 = 2'h2;
  // Register numbers that may not serve as pointer, base or index
  localparam logic [3:0] FIRST_REG_NUM = 4'h0;
  // Latency from request to result, in cycles
  localparam int EA_LATENCY = 1;
  // Operand addressing modes
  typedef enum logic [2:0] {
    MODE_REGISTER,
    MODE_LITERAL,
    MODE_POINTER,
    MODE_ABSOLUTE,
    MODE_INDEXED,
    MODE_BASE_DISP,
    MODE_BASE_INDEX,
    MODE_RELATIVE
  } addr_mode_t;
  // Target address spaces
  typedef enum logic [1:0] {
    SPACE_NONE,
    SPACE_DATA,
    SPACE_INSTR,
    SPACE_IO
  } space_t;
  // Register operand sizes
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG,
    SIZE_QUAD
  } reg_size_t;
endpackage : ea_pkg

// *** logic/effective_address_unit.sv ***
// Effective address generator: forms logical operand addresses.
// Fed by decode and register file; result goes to memory management.
// What this block does
// - Bit 31 selects small or large segment
// - Bit 31 zero: 15-bit segment, 16-bit offset
// - Bit 31 one: 7-bit segment, 24-bit offset
// - Add index, displacement; subtract for call/branch
// - Segmented result keeps base segment fields
// - Offset wraps at 16 or 24 bits
// - Linear uses 32-bit wraparound arithmetic
// - Word index sign-extended in linear mode
// - Short displacement sign-extended; branch zero-extends
// - Linear base, index exclude first registers
// - Pointer mode uses 16-bit register content in compact or I/O
// - Indexed mode adds address and index
// - Register mode selects register by size
// - Literal operand fetched from instruction space
// - Absolute mode uses instruction address
// - Translation only when memory management enabled
// - Compact wraps at 16 bits, no index+disp
// - I/O addresses take no arithmetic
module effective_address_unit
  import ea_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Representation and translation control
  input wire logic [1:0] I_REP_MODE,
  input wire logic I_MMU_ENABLE,
  // Request from decode
  input wire logic I_REQ_VALID,
  input wire ea_pkg::addr_mode_t I_MODE,
  input wire logic I_IO_SPACE,
  input wire logic I_USE_INDEX,
  input wire logic I_USE_DISP,
  input wire logic I_SUB_DISP,
  input wire logic I_DISP_ZERO_EXT,
  input wire logic [1:0] I_DISP_W,
  input wire ea_pkg::reg_size_t I_REG_SIZE,
  // Register numbers and values
  input wire logic [3:0] I_BASE_REG_NUM,
  input wire logic [3:0] I_INDEX_REG_NUM,
  input wire logic I_INDEX_LONG,
  input wire logic I_BASE_FROM_REG,
  input wire logic [31:0] I_BASE,
  input wire logic [31:0] I_INDEX,
  input wire logic [31:0] I_DISP,
  input wire logic [31:0] I_PC,
  // Result to memory management
  output logic O_EA_VALID,
  output logic [31:0] O_EA,
  output ea_pkg::space_t O_SPACE,
  output logic O_TRANSLATE,
  output logic O_REG_OPERAND,
  output logic [3:0] O_REG_NUM,
  output ea_pkg::reg_size_t O_REG_SIZE,
  output logic O_ILLEGAL
);
  import ea_pkg::*;

  // Extended operands
  logic [31:0] index_ext;
  logic [31:0] disp_ext;
  logic [31:0] sum;

  // Mode decodes
  wire logic is_compact = (I_REP_MODE == REP_COMPACT);
  wire logic is_seg = (I_REP_MODE == REP_SEGMENTED);
  wire logic is_reg = (I_MODE == MODE_REGISTER);
  wire logic is_lit = (I_MODE == MODE_LITERAL);
  wire logic is_ptr = (I_MODE == MODE_POINTER);
  wire logic is_abs = (I_MODE == MODE_ABSOLUTE);
  wire logic is_idx = (I_MODE == MODE_INDEXED);
  wire logic is_rel = (I_MODE == MODE_RELATIVE);

  // Terms used in the sum; absent terms are zero
  wire logic [31:0] idx_term = I_USE_INDEX ? index_ext : 32'h0;
  wire logic [31:0] disp_term = I_USE_DISP ? disp_ext : 32'h0;
  // Relative modes use the program counter as base
  wire logic [31:0] base_term = is_rel ? I_PC : I_BASE;

  // Sign/zero extension of index and displacement
  ea_operand_extend u_extend (
    .i_index(I_INDEX),
    .i_index_long(I_INDEX_LONG & ~is_compact),
    .i_disp(I_DISP),
    .i_disp_w(I_DISP_W),
    .i_disp_zero_ext(I_DISP_ZERO_EXT),
    .o_index(index_ext),
    .o_disp(disp_ext)
  );

  // Base plus index plus or minus displacement
  ea_offset_adder u_adder (
    .i_base(base_term),
    .i_index(idx_term),
    .i_disp(disp_term),
    .i_sub_disp(I_SUB_DISP),
    .o_sum(sum)
  );

  // Segment size taken from the base address
  wire logic large_seg = base_term[SEG_SIZE_BIT];
  // Small: keep bits 31..16 of base, wrap 16-bit offset
  wire logic [31:0] seg_small = {base_term[31:16], sum[15:0]};
  // Large: keep bits 31..24 of base, wrap 24-bit offset
  wire logic [31:0] seg_large = {base_term[31:24], sum[23:0]};
  wire logic [31:0] seg_ea = large_seg ? seg_large : seg_small;
  // Compact: 16-bit wrap, upper half from program counter
  wire logic [31:0] compact_ea = {I_PC[31:16], sum[15:0]};
  // I/O ports: 16-bit port address with no arithmetic
  wire logic [31:0] io_ea = {16'h0, (is_abs ? I_DISP[15:0] : I_BASE[15:0])};
  // Address computed per representation
  wire logic [31:0] mem_ea = is_compact ? compact_ea :
                             is_seg ? seg_ea : sum;
  // Memory or I/O target
  wire logic io_target = I_IO_SPACE & (is_ptr | is_abs);

  // Selected address per mode; pointer uses base register
  wire logic [31:0] next_ea = io_target ? io_ea :
                              is_compact & is_ptr ? {I_PC[31:16], I_BASE[15:0]} :
                              is_abs ? (is_compact ? {I_PC[31:16], I_DISP[15:0]} : I_DISP) :
                              is_idx & is_compact ? compact_ea : mem_ea;

  // Space chosen per mode
  wire space_t next_space = is_reg ? SPACE_NONE :
                            is_lit ? SPACE_INSTR :
                            io_target ? SPACE_IO :
                            is_rel ? SPACE_INSTR : SPACE_DATA;

  // Illegal register or term combinations
  wire logic bad_base = I_BASE_FROM_REG & (I_BASE_REG_NUM == FIRST_REG_NUM) &
                        ~is_reg & ~is_lit;
  wire logic bad_index = I_USE_INDEX & (I_INDEX_REG_NUM == FIRST_REG_NUM);
  wire logic bad_combo = is_compact & I_USE_INDEX & I_USE_DISP;
  wire logic bad_rep = (I_REP_MODE == 2'h3);
  wire logic next_illegal = bad_base | bad_index | bad_combo | bad_rep;

  // Output registers: one cycle after the request
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_EA_VALID <= 1'b0;
      O_EA <= 32'h0;
      O_SPACE <= SPACE_NONE;
      O_TRANSLATE <= 1'b0;
      O_REG_OPERAND <= 1'b0;
      O_REG_NUM <= 4'h0;
      O_REG_SIZE <= SIZE_BYTE;
      O_ILLEGAL <= 1'b0;
    end else begin
      O_EA_VALID <= I_REQ_VALID;
      if (I_REQ_VALID) begin
        O_EA <= is_reg | is_lit ? 32'h0 : next_ea;
        O_SPACE <= next_space;
        // Logical addresses go through translation only if enabled
        O_TRANSLATE <= I_MMU_ENABLE & ~is_reg & ~io_target;
        O_REG_OPERAND <= is_reg;
        O_REG_NUM <= I_BASE_REG_NUM;
        O_REG_SIZE <= I_REG_SIZE;
        O_ILLEGAL <= next_illegal;
      end
    end
  end

  // Checks: each request is answered on the very next edge
  property p_valid_follows;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID |=> O_EA_VALID;
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("result valid missing");
  property p_seg_keep;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_seg && !is_rel && !io_target && (is_idx || I_MODE == MODE_BASE_DISP)
      && !I_BASE[31] |=> O_EA[31:16] == $past(I_BASE[31:16]);
  endproperty
  a_seg_keep: assert property (p_seg_keep) else $error("segment fields changed");
  property p_large_keep;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_seg && I_MODE == MODE_BASE_DISP && I_BASE[31]
      |=> O_EA[31:24] == $past(I_BASE[31:24]);
  endproperty
  a_large_keep: assert property (p_large_keep) else $error("large segment changed");
  property p_lit_space;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_lit |=> O_SPACE == SPACE_INSTR;
  endproperty
  a_lit_space: assert property (p_lit_space) else $error("literal not in instruction space");
  property p_io_notrans;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && io_target |=> !O_TRANSLATE && O_EA[31:16] == 16'h0;
  endproperty
  a_io_notrans: assert property (p_io_notrans) else $error("io address translated");
  property p_mmu_off;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && !I_MMU_ENABLE |=> !O_TRANSLATE;
  endproperty
  a_mmu_off: assert property (p_mmu_off) else $error("translation while disabled");
  property p_compact_combo;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_compact && I_USE_INDEX && I_USE_DISP |=> O_ILLEGAL;
  endproperty
  a_compact_combo: assert property (p_compact_combo) else $error("index and disp allowed");
  property p_linear_sum;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && I_REP_MODE == REP_LINEAR && I_MODE == MODE_BASE_INDEX && !I_SUB_DISP
      && !I_USE_DISP && I_USE_INDEX && !I_INDEX_LONG
      |=> O_EA == $past(I_BASE + {{16{I_INDEX[15]}}, I_INDEX[15:0]});
  endproperty
  a_linear_sum: assert property (p_linear_sum) else $error("linear sum wrong");
  property p_reg_mode;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_reg |=> O_REG_OPERAND && O_SPACE == SPACE_NONE;
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register operand not flagged");

  // No answer without a request, and results hold between requests
  property p_valid_quiet;
    @(posedge I_REF_CLK) disable iff (I_RST)
    !I_REQ_VALID |=> !O_EA_VALID && $stable(O_EA) && $stable(O_ILLEGAL);
  endproperty
  a_valid_quiet: assert property (p_valid_quiet) else $error("answer without request");

  // Small segment offset wraps at 16 bits
  property p_small_wrap;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_seg && I_MODE == MODE_BASE_DISP && !I_USE_INDEX && I_USE_DISP
      && I_DISP_W != DISP_W8 && !I_BASE[31] |=> O_EA[15:0] ==
      $past(I_SUB_DISP ? I_BASE[15:0] - I_DISP[15:0] : I_BASE[15:0] + I_DISP[15:0]);
  endproperty
  a_small_wrap: assert property (p_small_wrap) else $error("small offset wrong");

  // Large segment offset wraps at 24 bits
  property p_large_wrap;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_seg && I_MODE == MODE_BASE_DISP && !I_USE_INDEX && I_USE_DISP
      && I_DISP_W == DISP_W32 && I_BASE[31] |=> O_EA[23:0] ==
      $past(I_SUB_DISP ? I_BASE[23:0] - I_DISP[23:0] : I_BASE[23:0] + I_DISP[23:0]);
  endproperty
  a_large_wrap: assert property (p_large_wrap) else $error("large offset wrong");

  // Call and branch subtract the displacement from the base
  property p_sub_disp;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && I_REP_MODE == REP_LINEAR && I_MODE == MODE_BASE_DISP && !I_USE_INDEX
      && I_USE_DISP && I_SUB_DISP && I_DISP_W == DISP_W32 |=> O_EA == $past(I_BASE - I_DISP);
  endproperty
  a_sub_disp: assert property (p_sub_disp) else $error("displacement not subtracted");

  // Branch displacement is extended with zeros
  property p_zero_ext;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && I_REP_MODE == REP_LINEAR && I_MODE == MODE_BASE_DISP && I_SUB_DISP
      && I_DISP_ZERO_EXT && I_DISP_W == DISP_W16 && !I_USE_INDEX && I_USE_DISP
      |=> O_EA == $past(I_BASE - {16'h0, I_DISP[15:0]});
  endproperty
  a_zero_ext: assert property (p_zero_ext) else $error("displacement not zero-extended");

  // Linear sum with a longword index wraps at 32 bits
  property p_linear_long;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && I_REP_MODE == REP_LINEAR && I_MODE == MODE_BASE_INDEX && I_USE_INDEX
      && !I_USE_DISP && I_INDEX_LONG |=> O_EA == $past(I_BASE + I_INDEX);
  endproperty
  a_linear_long: assert property (p_linear_long) else $error("linear long sum wrong");

  // Compact pointer takes the word register content as is
  property p_ptr_compact;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_compact && is_ptr && !I_IO_SPACE
      |=> O_EA[15:0] == $past(I_BASE[15:0]) && O_SPACE == SPACE_DATA;
  endproperty
  a_ptr_compact: assert property (p_ptr_compact) else $error("pointer address wrong");

  // Compact indexed adds the index word to the supplied address
  property p_idx_compact;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_compact && is_idx && I_USE_INDEX && !I_USE_DISP
      |=> O_EA[15:0] == $past(I_BASE[15:0] + I_INDEX[15:0]);
  endproperty
  a_idx_compact: assert property (p_idx_compact) else $error("indexed address wrong");

  // Absolute memory address passes unchanged outside compact
  property p_abs_mem;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && !is_compact && is_abs && !I_IO_SPACE
      |=> O_EA == $past(I_DISP) && O_SPACE == SPACE_DATA;
  endproperty
  a_abs_mem: assert property (p_abs_mem) else $error("absolute address wrong");

  // Compact memory addresses take their upper half from the program counter
  property p_compact_upper;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && is_compact && !is_reg && !is_lit && !io_target
      |=> O_EA[31:16] == $past(I_PC[31:16]);
  endproperty
  a_compact_upper: assert property (p_compact_upper) else $error("compact upper wrong");

  // The first register never serves as base, pointer or index
  property p_first_reg;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && ((I_BASE_FROM_REG && I_BASE_REG_NUM == FIRST_REG_NUM
      && (is_ptr || I_MODE == MODE_BASE_DISP || I_MODE == MODE_BASE_INDEX))
      || (I_USE_INDEX && I_INDEX_REG_NUM == FIRST_REG_NUM)) |=> O_ILLEGAL;
  endproperty
  a_first_reg: assert property (p_first_reg) else $error("first register accepted");

  // The unused representation setting is flagged
  property p_bad_rep;
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_REQ_VALID && I_REP_MODE == 2'h3 |=> O_ILLEGAL;
  endproperty
  a_bad_rep: assert property (p_bad_rep) else $error("unused setting accepted");

  // Scenario coverage
  c_seg_large: cover property (@(posedge I_REF_CLK) I_REQ_VALID && is_seg && large_seg);
  c_sub: cover property (@(posedge I_REF_CLK) I_REQ_VALID && I_SUB_DISP && I_USE_DISP);
  c_io: cover property (@(posedge I_REF_CLK) I_REQ_VALID && io_target);
  c_zero_ext: cover property (@(posedge I_REF_CLK) I_REQ_VALID && I_SUB_DISP && I_DISP_ZERO_EXT);
  c_compact_idx: cover property (@(posedge I_REF_CLK) I_REQ_VALID && is_compact && is_idx);
endmodule : effective_address_unit

// *** verification/effective_address_unit_tb_top.sv ***
// Self-checking bench for the effective address unit.
// Assumes one request per cycle and answers one cycle later.
module effective_address_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ea_pkg::*;
  // Expected answer; kind 0 illegal, 1 address, 2 register, 3 literal
  typedef struct {
    logic [31:0] ea;
    space_t sp;
    logic ill, trn;
    logic [1:0] kind;
    logic [5:0] rg;
  } note_t;
  note_t q[$];
  logic clk = 0, rst = 1, vld = 0, mmu = 0, io = 0, ui = 0, ud = 0;
  logic sub = 0, zx = 0, il = 0, we = 0, bfr;
  logic [1:0] rep = 0, dw = 0;
  addr_mode_t md = MODE_REGISTER;
  reg_size_t rs = SIZE_BYTE;
  logic [3:0] bn = 1, xn = 1, wn = 0;
  logic [31:0] dsp = 0, pc = 0, wd = 0, rb, rx, r;
  logic [31:0] rf [16];
  addr_mode_t ml [6] = '{MODE_POINTER, MODE_ABSOLUTE, MODE_INDEXED,
    MODE_LITERAL, MODE_RELATIVE, MODE_REGISTER};
  int n_errors = 0, checks = 0, seed = 11;
  // Base from a register only for these modes
  assign bfr = md inside {MODE_POINTER, MODE_BASE_DISP, MODE_BASE_INDEX};
  // Instruction-supplied base when no base register is named
  wire logic [31:0] bse = bfr ? rb : dsp;
  always #4 clk = ~clk;
  // Far side register file
  reg_file_model rf_u (.i_clk(clk), .i_we(we), .i_wnum(wn), .i_wdata(wd),
    .i_base_num(bn), .i_index_num(xn), .o_base(rb), .o_index(rx));
  effective_address_unit dut_u (.I_REF_CLK(clk), .I_RST(rst), .I_REP_MODE(rep),
    .I_MMU_ENABLE(mmu), .I_REQ_VALID(vld), .I_MODE(md), .I_IO_SPACE(io),
    .I_USE_INDEX(ui), .I_USE_DISP(ud), .I_SUB_DISP(sub), .I_DISP_ZERO_EXT(zx),
    .I_DISP_W(dw), .I_REG_SIZE(rs), .I_BASE_REG_NUM(bn), .I_INDEX_REG_NUM(xn),
    .I_INDEX_LONG(il), .I_BASE_FROM_REG(bfr), .I_BASE(bse), .I_INDEX(rx),
    .I_DISP(dsp), .I_PC(pc), .O_EA_VALID(), .O_EA(), .O_SPACE(), .O_TRANSLATE(),
    .O_REG_OPERAND(), .O_REG_NUM(), .O_REG_SIZE(), .O_ILLEGAL());
  // Compare and count
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Drive one request and note its expected answer
  task automatic go();
    note_t n;
    logic [31:0] b, x, d, s;
    b = md == MODE_RELATIVE ? pc : (md inside {MODE_INDEXED, MODE_ABSOLUTE}) ? dsp : rf[bn];
    x = il ? rf[xn] : {{16{rf[xn][15]}}, rf[xn][15:0]};
    d = dw == DISP_W8 ? {{24{dsp[7] & ~zx}}, dsp[7:0]}
      : dw == DISP_W16 ? {{16{dsp[15] & ~zx}}, dsp[15:0]} : dsp;
    s = b + (ui ? x : 32'h0) + (ud ? (sub ? -d : d) : 32'h0);
    if (rep == REP_COMPACT) s = {pc[31:16], s[15:0]};
    if (rep == REP_SEGMENTED) s = b[31] ? {b[31:24], s[23:0]} : {b[31:16], s[15:0]};
    if (io) s = {16'h0, b[15:0]};
    n.ea = (md inside {MODE_REGISTER, MODE_LITERAL}) ? 32'h0 : s;
    n.sp = md == MODE_REGISTER ? SPACE_NONE : io ? SPACE_IO :
      (md inside {MODE_LITERAL, MODE_RELATIVE}) ? SPACE_INSTR : SPACE_DATA;
    n.trn = mmu & ~io & (md != MODE_REGISTER);
    n.ill = (bfr && bn == 0) || (ui && xn == 0) || (rep == 0 && ui && ud) || rep == 3;
    n.kind = n.ill ? 0 : md == MODE_REGISTER ? 2 : md == MODE_LITERAL ? 3 : 1;
    n.rg = {bn, rs};
    q.push_back(n);
    vld = 1;
    @(negedge clk);
  endtask : go
  // Closing report
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Watch answers and match them to the oldest note
  always @(negedge clk) begin : mon
    note_t n;
    if (!rst && dut_u.O_EA_VALID === 1'b1) begin
      if (q.size() == 0) chk("spurious", 1, 0);
      else begin
        n = q.pop_front();
        chk("illegal", dut_u.O_ILLEGAL, n.ill);
        if (n.kind != 0) chk("ea", dut_u.O_EA, n.ea);
        if (n.kind != 0) chk("xlate", dut_u.O_TRANSLATE, n.trn);
        if (n.kind != 0) chk("space", dut_u.O_SPACE, n.sp);
        if (n.kind != 0) chk("regop", dut_u.O_REG_OPERAND, n.kind == 2);
        if (n.kind == 2) chk("reg", {dut_u.O_REG_OPERAND, dut_u.O_REG_NUM,
          dut_u.O_REG_SIZE}, {1'b1, n.rg});
      end
    end
  end
  // Main sequence
  initial begin
    repeat (7) @(negedge clk);
    chk("reset", {dut_u.O_EA_VALID, dut_u.O_ILLEGAL}, 0);
    @(negedge clk);
    rst = 0;
    // Load the register file
    for (int i = 0; i < 16; i++) begin
      wd = $random(seed);
      // Every other pair of registers (2, 3, 6, 7 and so on) holds a large-segment base
      wd[31] = i[1];
      wn = 4'(i);
      rf[i] = wd;
      we = 1;
      @(negedge clk);
    end
    we = 0;
    // Random back-to-back base, index and displacement sums
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      rep = r[1:0] == 2'h3 ? REP_LINEAR : r[1:0];
      ui = ~r[2];
      ud = r[2] | (r[18] & (rep != REP_COMPACT));
      md = ui ? MODE_BASE_INDEX : MODE_BASE_DISP;
      bn = r[7:4] | 4'h1;
      xn = r[11:8] | 4'h1;
      dw = r[13:12] == 2'h3 ? DISP_W16 : r[13:12];
      sub = r[14];
      zx = r[14] & r[15];
      il = r[16];
      mmu = r[17];
      dsp = $random(seed);
      pc = $random(seed);
      go();
    end
    // Every other mode in every representation, memory and I/O
    for (int p = 0; p < 3; p++) for (int k = 0; k < 2; k++) for (int m = 0; m < 6; m++) begin
      rep = 2'(p);
      md = ml[m];
      io = k[0] & (md inside {MODE_POINTER, MODE_ABSOLUTE});
      ui = md == MODE_INDEXED;
      ud = md == MODE_RELATIVE;
      rs = reg_size_t'(2'(k * 2 + p));
      mmu = p[0];
      bn = 4'h3;
      xn = 4'h5;
      dsp = $random(seed);
      go();
    end
    // Refused register numbers, combined terms and the unused setting
    for (int k = 0; k < 4; k++) begin
      md = MODE_BASE_INDEX;
      ui = 1;
      ud = 1;
      bn = k == 1 ? 4'h0 : 4'h1;
      xn = k == 2 ? 4'h0 : 4'h2;
      rep = k == 0 ? 2'h3 : k == 3 ? REP_COMPACT : REP_LINEAR;
      go();
    end
    vld = 0;
    for (int w = 0; w < 10 && q.size() != 0; w++) @(negedge clk);
    chk("pending", q.size(), 0);
    print_verdict();
  end
endmodule : effective_address_unit_tb_top

// *** verification/reg_file_model.sv ***
// Register file model feeding base and index values to the unit.
// Assumes bench writes on the clock; reads are combinational.
module reg_file_model (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [3:0] i_wnum,
  input wire logic [31:0] i_wdata,
  // Read ports
  input wire logic [3:0] i_base_num,
  input wire logic [3:0] i_index_num,
  output logic [31:0] o_base,
  output logic [31:0] o_index
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sixteen general registers
  logic [31:0] regs [16];
  // Store on write strobe
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      regs[i_wnum] <= i_wdata;
    end
  end
  // Both operands read at once
  assign o_base = regs[i_base_num];
  assign o_index = regs[i_index_num];
endmodule : reg_file_model
